// ---- vocc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Primary format codes 0,3,5,6,7; others reserved
// - Primary filter: none, replicate, interpolate
// - Key register holds three lower bound bytes
// - Precision n compares bits 7 down to 7-n
// - Key source clear: pixel key bit decides
// - Key source set: range keying except 1555
// - Signed accumulator initial value, bits 11-0
// - Secondary format codes 1-7; zero reserved
// - Secondary filter codes 0-3; others reserved
// - Chroma upper bounds in three bytes
// - First scale constant is width minus one
// - Second scale constant is signed, negative
// - Secondary control, scale and blend fields apply at next vertical sync
// - Blend coefficients in bits 4-2, 12-10
// - Modes 0 and 1 are opaque overlays
// - Dissolve and fade blend arithmetic modes
// - Modes 5,6 key; 4,7 reserved
// - Primary start address A, 22 bits
// - Primary start address B, 22 bits
// - Control registers reset to zero
// - Buffer select chooses address A or B
module vocc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic vsync,
    input wire logic [vocc_pkg::VOCC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [vocc_pkg::VOCC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output vocc_pkg::vocc_cfg_s cfg,
    output vocc_pkg::vocc_key_s key_cfg
);
    import vocc_pkg::*;

    vocc_state_s s_q;
    vocc_state_s s_d;
    logic wr_go;
    logic vs_rise;
    logic [31:0] wmask;
    logic [31:0] rd_val;
    logic rd_hit;
    logic wr_hit;

    // ==========================================
    // Bus handshakes
    assign s_axi_awready = !s_q.aw_hold && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_hold && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // Write fires once both address and data are present, held or arriving
    logic aw_now;
    logic w_now;
    logic [VOCC_AW-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    assign aw_now = s_q.aw_hold || (s_axi_awvalid && s_axi_awready);
    assign w_now = s_q.w_hold || (s_axi_wvalid && s_axi_wready);
    assign wr_go = aw_now && w_now;
    assign wa = s_q.aw_hold ? s_q.awaddr : s_axi_awaddr;
    assign wd = s_q.w_hold ? s_q.wdata : s_axi_wdata;
    assign ws = s_q.w_hold ? s_q.wstrb : s_axi_wstrb;
    assign wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    assign vs_rise = vsync && !s_q.vs_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] be, input logic [31:0] msk);
        merge = ((old & ~be) | (nw & be)) & msk;
    endfunction

    // ==========================================
    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            VOCC_OFF_PCTL: rd_val = s_q.pctl;
            VOCC_OFF_KEY: rd_val = s_q.key;
            VOCC_OFF_SCTL: rd_val = s_q.sctl_p;
            VOCC_OFF_CHUB: rd_val = s_q.chub;
            VOCC_OFF_STRC: rd_val = s_q.strc_p;
            VOCC_OFF_BLND: rd_val = s_q.blnd_p;
            VOCC_OFF_PBA: rd_val = {10'h000, s_q.pba};
            VOCC_OFF_PBB: rd_val = {10'h000, s_q.pbb};
            VOCC_OFF_DBUF: rd_val = {31'h0000_0000, s_q.buf_sel};
            default: begin
                rd_val = VOCC_RST_ZERO;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        wr_hit = 1'b0;
        s_d = s_q;
        s_d.vs_q = vsync;
        // Bus channel capture
        if (s_axi_awvalid && s_axi_awready && !wr_go) begin
            s_d.aw_hold = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !wr_go) begin
            s_d.w_hold = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = rd_hit ? 2'h0 : 2'h2;
        end
        // Deferred fields land together; a same-cycle write is caught next vsync
        if (vs_rise) begin
            s_d.sctl_a = s_q.sctl_p;
            s_d.strc_a = s_q.strc_p;
            s_d.blnd_a = s_q.blnd_p;
        end
        if (wr_go) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.bvalid = 1'b1;
            wr_hit = 1'b1;
            unique case (wa)
                VOCC_OFF_PCTL: s_d.pctl = merge(s_q.pctl, wd, wmask, VOCC_MSK_PCTL);
                VOCC_OFF_KEY: s_d.key = merge(s_q.key, wd, wmask, VOCC_MSK_KEY);
                VOCC_OFF_SCTL: s_d.sctl_p = merge(s_q.sctl_p, wd, wmask, VOCC_MSK_SCTL);
                VOCC_OFF_CHUB: s_d.chub = merge(s_q.chub, wd, wmask, VOCC_MSK_CHUB);
                VOCC_OFF_STRC: s_d.strc_p = merge(s_q.strc_p, wd, wmask, VOCC_MSK_STRC);
                VOCC_OFF_BLND: s_d.blnd_p = merge(s_q.blnd_p, wd, wmask, VOCC_MSK_BLND);
                VOCC_OFF_PBA: s_d.pba = 22'(merge({10'h000, s_q.pba}, wd, wmask,
                                                  VOCC_MSK_PBUF));
                VOCC_OFF_PBB: s_d.pbb = 22'(merge({10'h000, s_q.pbb}, wd, wmask,
                                                  VOCC_MSK_PBUF));
                VOCC_OFF_DBUF: s_d.buf_sel = (ws[0]) ? wd[0] : s_q.buf_sel;
                default: wr_hit = 1'b0;
            endcase
            s_d.bresp = wr_hit ? 2'h0 : 2'h2;
        end
    end

    // ==========================================
    // State register; address registers are cleared too, a harmless tightening
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Decoded configuration, registered for clean outputs
    vocc_cfg_s cfg_d;
    vocc_key_s key_d;
    logic [2:0] prec;

    always_comb begin
        cfg_d.pri_format = s_q.pctl[VOCC_FMT_LO +: 3];
        cfg_d.pri_filter = s_q.pctl[VOCC_FLT_LO +: 3];
        unique case (cfg_d.pri_format)
            VOCC_PF_PAL8, VOCC_PF_K1555, VOCC_PF_R565,
            VOCC_PF_R888, VOCC_PF_X8888: cfg_d.pri_fmt_ok = 1'b1;
            default: cfg_d.pri_fmt_ok = 1'b0;
        endcase
        cfg_d.pri_flt_ok = (cfg_d.pri_filter <= 3'h2);
        cfg_d.sec_format = s_q.sctl_a[VOCC_FMT_LO +: 3];
        cfg_d.sec_filter = s_q.sctl_a[VOCC_FLT_LO +: 3];
        cfg_d.sec_fmt_ok = (cfg_d.sec_format != 3'h0);
        cfg_d.sec_flt_ok = (cfg_d.sec_filter <= 3'h3);
        cfg_d.acc_init = s_q.sctl_a[11:0];
        cfg_d.first_k = s_q.strc_a[10:0];
        cfg_d.second_k = s_q.strc_a[26:16];
        cfg_d.mode = s_q.blnd_a[26:24];
        // Mode 2 uses 8-Kp as secondary weight in place of Ks
        unique case (cfg_d.mode)
            VOCC_CM_SEC_TOP, VOCC_CM_PRI_TOP: cfg_d.mode_ok = 1'b1;
            VOCC_CM_DISSOLVE, VOCC_CM_FADE: cfg_d.mode_ok = 1'b1;
            VOCC_CM_KEY_PRI, VOCC_CM_KEY_SEC: cfg_d.mode_ok = 1'b1;
            default: cfg_d.mode_ok = 1'b0;
        endcase
        cfg_d.kp = s_q.blnd_a[12:10];
        cfg_d.ks = (cfg_d.mode == VOCC_CM_DISSOLVE) ?
                   3'(4'h8 - {1'b0, s_q.blnd_a[12:10]}) : s_q.blnd_a[4:2];
        cfg_d.fetch_addr = (s_q.buf_sel ? s_q.pbb : s_q.pba) & VOCC_QW_MASK;
        prec = s_q.key[VOCC_PREC_LO +: 3];
        key_d.key_src = s_q.key[VOCC_KSRC_BIT];
        key_d.cmp_mask = 8'(9'h1FF << (3'h7 - prec));
        key_d.lower = s_q.key[23:0];
        key_d.upper = s_q.chub[23:0];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg <= '0;
            key_cfg <= '0;
        end else begin
            cfg <= cfg_d;
            key_cfg <= key_d;
        end
    end

    // ==========================================
    // Checks
    AST_VSYNC_APPLY: assert property (@(posedge clk) disable iff (!rst_b)
        (vsync && !s_q.vs_q) |=> ##1 (cfg.mode == $past(s_q.blnd_p[26:24], 2)))
        else $error("blend mode not applied at vsync");
    AST_HOLD_NO_VSYNC: assert property (@(posedge clk) disable iff (!rst_b)
        !(vsync && !s_q.vs_q) |=> $stable(s_q.sctl_a))
        else $error("secondary control changed without vsync");
    AST_ALIGN: assert property (@(posedge clk) disable iff (!rst_b)
        cfg.fetch_addr[2:0] == 3'h0)
        else $error("fetch address not quadword aligned");
    // Mask must be grouped with the mux, equality binds tighter than bitwise and
    AST_SELECT: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (cfg.fetch_addr == (($past(s_q.buf_sel) ? $past(s_q.pbb) : $past(s_q.pba))
        & VOCC_QW_MASK)))
        else $error("wrong primary buffer chosen");
    AST_PREC: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.key[26:24] == 3'h0) |=> (key_cfg.cmp_mask == 8'h80))
        else $error("precision mask wrong");
    AST_DISSOLVE: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.blnd_a[26:24] == 3'h2) |=> (4'(cfg.kp) + 4'(cfg.ks) == 4'h8 || cfg.kp == 3'h0))
        else $error("dissolve weights do not sum to eight");
    AST_MODE_RSV: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.blnd_a[26:24] == 3'h4 || s_q.blnd_a[26:24] == 3'h7) |=> !cfg.mode_ok)
        else $error("reserved mode flagged valid");
    AST_SFMT: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.sctl_a[26:24] == 3'h0) |=> !cfg.sec_fmt_ok)
        else $error("reserved secondary format accepted");
    AST_RESET: assert property (@(posedge clk)
        !rst_b |=> (s_q.pctl == '0 && s_q.key == '0 && s_q.blnd_p == '0))
        else $error("control not zero after reset");
    AST_BRESP: assert property (@(posedge clk) disable iff (!rst_b)
        wr_go |=> s_axi_bvalid)
        else $error("write not answered");
    COV_VSYNC: cover property (@(posedge clk) disable iff (!rst_b) vs_rise && wr_go);
    COV_FADE: cover property (@(posedge clk) disable iff (!rst_b) cfg.mode == 3'h3);
    COV_BUFB: cover property (@(posedge clk) disable iff (!rst_b) s_q.buf_sel);
endmodule
`default_nettype wire

// ---- vocc_pkg.sv ----
package vocc_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [15:0] VOCC_OFF_PCTL = 16'h8180;
    localparam logic [15:0] VOCC_OFF_KEY = 16'h8184;
    localparam logic [15:0] VOCC_OFF_SCTL = 16'h8190;
    localparam logic [15:0] VOCC_OFF_CHUB = 16'h8194;
    localparam logic [15:0] VOCC_OFF_STRC = 16'h8198;
    localparam logic [15:0] VOCC_OFF_BLND = 16'h81A0;
    localparam logic [15:0] VOCC_OFF_PBA = 16'h81C0;
    localparam logic [15:0] VOCC_OFF_PBB = 16'h81C4;
    localparam logic [15:0] VOCC_OFF_DBUF = 16'h81CC;
    localparam int VOCC_AW = 16;

    // ==========================================
    // Writable bit masks; reserved bits read zero
    localparam logic [31:0] VOCC_MSK_PCTL = 32'h7700_0000;
    localparam logic [31:0] VOCC_MSK_KEY = 32'h17FF_FFFF;
    localparam logic [31:0] VOCC_MSK_SCTL = 32'h7700_0FFF;
    localparam logic [31:0] VOCC_MSK_CHUB = 32'h00FF_FFFF;
    localparam logic [31:0] VOCC_MSK_STRC = 32'h07FF_07FF;
    localparam logic [31:0] VOCC_MSK_BLND = 32'h0700_1C1C;
    localparam logic [31:0] VOCC_MSK_PBUF = 32'h003F_FFFF;
    localparam logic [31:0] VOCC_MSK_DBUF = 32'h0000_0001;
    localparam logic [31:0] VOCC_RST_ZERO = 32'h0000_0000;
    localparam logic [21:0] VOCC_QW_MASK = 22'h3F_FFF8;

    // ==========================================
    // Field positions
    localparam int VOCC_FMT_LO = 24;
    localparam int VOCC_FLT_LO = 28;
    localparam int VOCC_KSRC_BIT = 28;
    localparam int VOCC_PREC_LO = 24;

    typedef enum logic [2:0] {
        VOCC_PF_PAL8 = 3'h0, VOCC_PF_K1555 = 3'h3, VOCC_PF_R565 = 3'h5,
        VOCC_PF_R888 = 3'h6, VOCC_PF_X8888 = 3'h7
    } vocc_pfmt_e;
    typedef enum logic [2:0] {
        VOCC_CM_SEC_TOP = 3'h0, VOCC_CM_PRI_TOP = 3'h1, VOCC_CM_DISSOLVE = 3'h2,
        VOCC_CM_FADE = 3'h3, VOCC_CM_KEY_PRI = 3'h5, VOCC_CM_KEY_SEC = 3'h6
    } vocc_mode_e;

    typedef struct packed {
        logic [31:0] pctl;
        logic [31:0] key;
        logic [31:0] sctl_p;
        logic [31:0] sctl_a;
        logic [31:0] chub;
        logic [31:0] strc_p;
        logic [31:0] strc_a;
        logic [31:0] blnd_p;
        logic [31:0] blnd_a;
        logic [21:0] pba;
        logic [21:0] pbb;
        logic buf_sel;
        logic aw_hold;
        logic [VOCC_AW-1:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic vs_q;
    } vocc_state_s;

    typedef struct packed {
        logic [2:0] pri_format;
        logic [2:0] pri_filter;
        logic pri_fmt_ok;
        logic pri_flt_ok;
        logic [2:0] sec_format;
        logic [2:0] sec_filter;
        logic sec_fmt_ok;
        logic sec_flt_ok;
        logic signed [11:0] acc_init;
        logic [10:0] first_k;
        logic signed [10:0] second_k;
        logic [2:0] mode;
        logic mode_ok;
        logic [2:0] kp;
        logic [2:0] ks;
        logic [21:0] fetch_addr;
    } vocc_cfg_s;

    typedef struct packed {
        logic key_src;
        logic [7:0] cmp_mask;
        logic [23:0] lower;
        logic [23:0] upper;
    } vocc_key_s;
endpackage

// ---- video_overlay_compositor_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module video_overlay_compositor_config_tb;
    import vocc_pkg::*;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic vsync = 1'b0;
    logic [VOCC_AW-1:0] awaddr = '0;
    logic [VOCC_AW-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    vocc_cfg_s cfg;
    vocc_key_s key_cfg;
    int num_errors = 0;
    int checked = 0;
    logic [15:0] ra [8] = '{VOCC_OFF_PCTL, VOCC_OFF_KEY, VOCC_OFF_SCTL, VOCC_OFF_CHUB,
                           VOCC_OFF_STRC, VOCC_OFF_BLND, VOCC_OFF_PBA, VOCC_OFF_PBB};
    logic [31:0] rm [8] = '{VOCC_MSK_PCTL, VOCC_MSK_KEY, VOCC_MSK_SCTL, VOCC_MSK_CHUB,
                           VOCC_MSK_STRC, VOCC_MSK_BLND, VOCC_MSK_PBUF, VOCC_MSK_PBUF};

    always #2.5 clk = ~clk;

    vocc_top dut (.clk(clk), .rst_b(rst_b), .vsync(vsync),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg(cfg), .key_cfg(key_cfg));

    // ==========================================
    // Bus and compare tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Leading edge keeps a new request off the edge that closed the last one
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        if (n >= 100) num_errors++;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        if (n >= 100) num_errors++;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", e, rdata);
    endtask

    task automatic frame_sync();
        @(posedge clk);
        vsync <= 1'b1;
        repeat (2) @(posedge clk);
        vsync <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        logic [2:0] f;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i < 6) rd_chk(ra[i], VOCC_RST_ZERO, 2'h0);
            wr(ra[i], rm[i], 2'h0);
            rd_chk(ra[i], rm[i], 2'h0);
        end
        wr(16'h8188, 32'h0000_0001, 2'h2);
        rd_chk(16'h8188, 32'h0000_0000, 2'h2);
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            wr(VOCC_OFF_PCTL, {1'b0, f, 1'b0, f, 24'h00_0000}, 2'h0);
            repeat (3) @(posedge clk);
            chk("pri_format", 32'(f), 32'(cfg.pri_format));
            chk("pri_fmt_ok", 32'(f == 0 || f == 3 || f >= 5), 32'(cfg.pri_fmt_ok));
            chk("pri_filter", 32'(f), 32'(cfg.pri_filter));
            chk("pri_flt_ok", 32'(f < 3), 32'(cfg.pri_flt_ok));
            wr(VOCC_OFF_KEY, {3'h0, f[0], 1'b0, f, 24'hC3_5AA5}, 2'h0);
            repeat (3) @(posedge clk);
            chk("lower", 32'h00C3_5AA5, 32'(key_cfg.lower));
            chk("cmp_mask", 32'(8'(8'hFF << (7 - i))), 32'(key_cfg.cmp_mask));
            chk("key_src", 32'(f[0]), 32'(key_cfg.key_src));
        end
        wr(VOCC_OFF_CHUB, 32'h0011_2233, 2'h0);
        repeat (3) @(posedge clk);
        chk("upper", 32'h0011_2233, 32'(key_cfg.upper));
        // Single byte lane: only bits 15-8 may change
        wstrb <= 4'h2;
        wr(VOCC_OFF_CHUB, 32'h00AA_CCBB, 2'h0);
        wstrb <= 4'hF;
        rd_chk(VOCC_OFF_CHUB, 32'h0011_CC33, 2'h0);
        // Reserved codes are swept too: decode must flag them, not reject the write
        for (int i = 0; i < 8; i++) begin
            f = 3'(i);
            wr(VOCC_OFF_SCTL, {1'b0, f, 1'b0, f, 12'h000, 12'hFF0 | 12'(f)}, 2'h0);
            wr(VOCC_OFF_STRC, {5'h00, 11'h7F0 + 11'(f), 5'h00, 11'h13F}, 2'h0);
            wr(VOCC_OFF_BLND, {5'h00, f, 11'h000, 3'h3, 5'h00, 3'h2, 2'h0}, 2'h0);
            rd_chk(VOCC_OFF_BLND, {5'h00, f, 11'h000, 3'h3, 5'h00, 3'h2, 2'h0}, 2'h0);
            chk("mode_held", (i == 0) ? 32'h0 : 32'(i - 1), 32'(cfg.mode));
            frame_sync();
            chk("mode", 32'(f), 32'(cfg.mode));
            chk("mode_ok", 32'(f != 4 && f != 7), 32'(cfg.mode_ok));
            chk("kp", 32'h3, 32'(cfg.kp));
            chk("ks", (f == 2) ? 32'h5 : 32'h2, 32'(cfg.ks));
            chk("sec_format", 32'(f), 32'(cfg.sec_format));
            chk("sec_fmt_ok", 32'(f != 0), 32'(cfg.sec_fmt_ok));
            chk("sec_filter", 32'(f), 32'(cfg.sec_filter));
            chk("sec_flt_ok", 32'(f < 4), 32'(cfg.sec_flt_ok));
            chk("acc_init", {20'h0, 12'hFF0 | 12'(f)}, {20'h0, cfg.acc_init});
            chk("first_k", 32'h13F, {21'h0, cfg.first_k});
            chk("second_k", {21'h0, 11'h7F0 + 11'(f)}, {21'h0, cfg.second_k});
        end
        wr(VOCC_OFF_PBA, 32'h003F_FFFF, 2'h0);
        wr(VOCC_OFF_PBB, 32'h0012_3457, 2'h0);
        wr(VOCC_OFF_DBUF, 32'h0000_0000, 2'h0);
        repeat (3) @(posedge clk);
        chk("fetch_a", 32'h003F_FFF8, {10'h0, cfg.fetch_addr});
        wr(VOCC_OFF_DBUF, 32'h0000_0001, 2'h0);
        repeat (3) @(posedge clk);
        chk("fetch_b", 32'h0012_3450, {10'h0, cfg.fetch_addr});
        rd_chk(VOCC_OFF_PBB, 32'h0012_3457, 2'h0);
        rd_chk(VOCC_OFF_DBUF, 32'h0000_0001, 2'h0);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
